// file: rtl/psx_defines.svh
// constants for the port strobe and external memory strobe block
`ifndef PSX_DEFINES_SVH
`define PSX_DEFINES_SVH
// strobe active time in clock cycles
`define PSX_STROBE_CYCLES 2
// delay from port write to write strobe
`define PSX_WR_DELAY 2
// delay from port read to read strobe
`define PSX_RD_DELAY 3
// port sample pipeline depth (value read comes from the first stage, pins one cycle before the read)
`define PSX_SAMPLE_DEPTH 3
// reset values
`define PSX_PORT_RESET 8'h00
`define PSX_ADDR_RESET 16'h0000
// stretch field width
`define PSX_STRETCH_W 3
`endif

// file: rtl/psx_pkg.sv
// types shared by the port strobe block
package psx_pkg;
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
    } psx_strobe_type;
    typedef struct packed {
        logic [15:0] addr;
        logic addr_oe_n;
        logic [7:0] data;
        logic data_oe_n;
    } psx_bus_type;
    typedef enum logic [3:0] {
        PSX_IDLE = 4'h1,
        PSX_WAIT = 4'h2,
        PSX_STB = 4'h4,
        PSX_DONE = 4'h8
    } psx_state_type;
endpackage : psx_pkg

// file: rtl/psx_pulse.sv
// delayed fixed-width pulse generator for one strobe
`timescale 1ns/1ps
`default_nettype none
module psx_pulse #(
    parameter logic [3:0] DELAY = 4'h2,
    parameter logic [3:0] WIDTH = 4'h2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trig,
    output logic busy,
    output logic active
);
    psx_pkg::psx_state_type state_q;
    logic [3:0] cnt_q;

    // ------------------------------------------------------------
    // delay then hold state machine
    // ------------------------------------------------------------
    // a trigger while busy is dropped; firmware cannot access faster than this
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= psx_pkg::PSX_IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                psx_pkg::PSX_IDLE: begin
                    if (trig) begin
                        state_q <= psx_pkg::PSX_WAIT;
                        cnt_q <= 4'h1;
                    end
                end
                psx_pkg::PSX_WAIT: begin
                    if (cnt_q == DELAY) begin
                        state_q <= psx_pkg::PSX_STB;
                        cnt_q <= 4'h1;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                psx_pkg::PSX_STB: begin
                    if (cnt_q == WIDTH) begin
                        state_q <= psx_pkg::PSX_IDLE;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= psx_pkg::PSX_IDLE;
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end

    assign busy = (state_q != psx_pkg::PSX_IDLE);
    assign active = (state_q == psx_pkg::PSX_STB);
endmodule : psx_pulse
`default_nettype wire

// file: rtl/psx_port_strobe.sv
// port strobe generation and external data memory strobes
`timescale 1ns/1ps
`default_nettype none
`include "psx_defines.svh"

module psx_port_strobe (
    input wire logic clk,
    input wire logic rst,
    input wire logic port_strobe_enable,
    input wire logic port_wr,
    input wire logic [7:0] port_wdata,
    input wire logic port_rd,
    input wire logic [7:0] port_pins_in,
    output logic [7:0] port_rdata,
    output logic [7:0] third_io_port_out,
    input wire logic xmem_req,
    input wire logic xmem_write,
    input wire logic xmem_code,
    input wire logic xmem_ptr_sel,
    input wire logic [15:0] xmem_addr,
    input wire logic [7:0] xmem_wdata,
    input wire logic [`PSX_STRETCH_W-1:0] stretch,
    output logic xmem_busy,
    output logic [7:0] xmem_rdata,
    input wire logic [7:0] bus_data_in,
    output psx_pkg::psx_bus_type bus_out,
    output psx_pkg::psx_strobe_type strobe_out
);
    logic [7:0] port_q;
    logic [7:0] samp_q [`PSX_SAMPLE_DEPTH];
    logic wr_busy, wr_act, rd_busy, rd_act;
    logic cyc_q, wr_q, code_q, sel_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [3:0] len_q, cnt_q;
    logic mem_stb;
    logic rd_n_d, wr_n_d, cs_n_d, addr_oe_n_d, data_oe_n_d;

    // ------------------------------------------------------------
    // port output latch and input sampling
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            port_q <= `PSX_PORT_RESET;
        end else if (port_wr) begin
            port_q <= port_wdata;
        end
    end

    // pins are sampled every cycle, never on the strobe itself
    genvar gi;
    generate
        for (gi = 0; gi < `PSX_SAMPLE_DEPTH; gi++) begin : g_samp
            // head stage split off so no stage ever indexes below zero
            if (gi == 0) begin : g_head
                always_ff @(posedge clk) begin
                    if (rst) begin
                        samp_q[gi] <= `PSX_PORT_RESET;
                    end else begin
                        samp_q[gi] <= port_pins_in;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge clk) begin
                    if (rst) begin
                        samp_q[gi] <= `PSX_PORT_RESET;
                    end else begin
                        samp_q[gi] <= samp_q[gi-1];
                    end
                end
            end
        end
    endgenerate

    // read captures the value on the pins; the rd_n strobe pin follows four cycles later
    always_ff @(posedge clk) begin
        if (rst) begin
            port_rdata <= `PSX_PORT_RESET;
        end else if (port_rd) begin
            port_rdata <= samp_q[0];
        end
    end

    // ------------------------------------------------------------
    // port strobe pulse generators
    // ------------------------------------------------------------
    // triggers gated by the enable so disabled accesses stay silent
    psx_pulse #(.DELAY(4'(`PSX_WR_DELAY)), .WIDTH(4'(`PSX_STROBE_CYCLES))) u_wr_pulse (
        .clk(clk),
        .rst(rst),
        .trig(port_wr && port_strobe_enable),
        .busy(wr_busy),
        .active(wr_act)
    );

    psx_pulse #(.DELAY(4'(`PSX_RD_DELAY)), .WIDTH(4'(`PSX_STROBE_CYCLES))) u_rd_pulse (
        .clk(clk),
        .rst(rst),
        .trig(port_rd && port_strobe_enable),
        .busy(rd_busy),
        .active(rd_act)
    );

    // ------------------------------------------------------------
    // external memory cycle sequencer
    // ------------------------------------------------------------
    // cycle run and length counter; a request during a cycle is not taken
    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (!cyc_q) begin
            if (xmem_req) begin
                cyc_q <= 1'b1;
                cnt_q <= 4'h0;
            end
        end else if (cnt_q == len_q) begin
            cyc_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // request attributes held for the whole cycle so pins cannot shift mid-cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            code_q <= 1'b0;
            sel_q <= 1'b0;
            addr_q <= `PSX_ADDR_RESET;
            wdata_q <= 8'h00;
            len_q <= 4'h0;
        end else if (!cyc_q && xmem_req) begin
            wr_q <= xmem_write && !xmem_code;
            code_q <= xmem_code;
            sel_q <= xmem_ptr_sel;
            addr_q <= xmem_addr;
            wdata_q <= xmem_wdata;
            // stretch lengthens only data cycles; code fetches use the base length
            len_q <= xmem_code ? 4'h2 : 4'h2 + 4'(stretch);
        end
    end

    // strobe covers all but the first address cycle; code fetches have no strobe
    assign mem_stb = cyc_q && (cnt_q != 4'h0) && !code_q;

    // read data captured at the last strobe cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            xmem_rdata <= 8'h00;
        end else if (mem_stb && !wr_q && cnt_q == len_q) begin
            xmem_rdata <= bus_data_in;
        end
    end

    // ------------------------------------------------------------
    // next pin levels
    // ------------------------------------------------------------
    // the pins are shared, so port strobes and memory strobes are ORed
    always_comb begin
        rd_n_d = !(rd_act || (mem_stb && !wr_q));
        wr_n_d = !(wr_act || (mem_stb && wr_q));
        cs_n_d = !(cyc_q && !code_q);
        // first pointer drives only under a strobe, second throughout
        // a fetch has no strobe here, so its address stands for the whole cycle
        addr_oe_n_d = !(cyc_q && (sel_q || mem_stb || code_q));
        data_oe_n_d = !(cyc_q && wr_q);
    end

    // ------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------
    // strobes idle high through reset so the far side sees no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_out <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
        end else begin
            strobe_out.rd_n <= rd_n_d;
            strobe_out.wr_n <= wr_n_d;
            strobe_out.cs_n <= cs_n_d;
        end
    end

    // address and data bus with their drive enables
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_out <= '{addr: `PSX_ADDR_RESET, addr_oe_n: 1'b1, data: 8'h00, data_oe_n: 1'b1};
        end else begin
            bus_out.addr <= addr_q;
            bus_out.addr_oe_n <= addr_oe_n_d;
            bus_out.data <= wdata_q;
            bus_out.data_oe_n <= data_oe_n_d;
        end
    end

    // busy covers the port pulses too, so firmware can space its accesses
    always_ff @(posedge clk) begin
        if (rst) begin
            xmem_busy <= 1'b0;
        end else begin
            xmem_busy <= cyc_q || xmem_req || wr_busy || rd_busy;
        end
    end

    // port latch to the pins, one cycle behind the firmware write
    always_ff @(posedge clk) begin
        if (rst) begin
            third_io_port_out <= `PSX_PORT_RESET;
        end else begin
            third_io_port_out <= port_q;
        end
    end
endmodule : psx_port_strobe
`default_nettype wire

// file: dv/psx_port_strobe_assertions.sv
// checker for the port strobe block
`timescale 1ns/1ps
`default_nettype none
`include "psx_defines.svh"
module psx_port_strobe_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic port_strobe_enable,
    input wire logic port_wr,
    input wire logic [7:0] port_wdata,
    input wire logic port_rd,
    input wire logic [7:0] port_pins_in,
    input wire logic [7:0] port_rdata,
    input wire logic [7:0] third_io_port_out,
    input wire logic xmem_req,
    input wire logic xmem_write,
    input wire logic xmem_code,
    input wire logic xmem_ptr_sel,
    input wire logic [7:0] xmem_wdata,
    input wire logic [`PSX_STRETCH_W-1:0] stretch,
    input wire logic xmem_busy,
    input wire psx_pkg::psx_bus_type bus_out,
    input wire psx_pkg::psx_strobe_type strobe_out
);
    logic pq, cq, sq, wq;
    logic [`PSX_STRETCH_W-1:0] st_q;
    logic [7:0] wd_q, xd_q;
    logic [3:0] wl_q;
    wire logic [3:0] len = pq ? 4'h2 : 4'h2 + 4'(st_q);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // kind of the last access, so strobe length can be judged
    always_ff @(posedge clk) begin
        if (port_wr || port_rd) pq <= 1'b1;
        if (port_wr) wd_q <= port_wdata;
        if (xmem_req && !xmem_busy) begin
            {pq, cq, sq, wq, st_q, xd_q} <= {1'b0, xmem_code, xmem_ptr_sel, xmem_write, stretch, xmem_wdata};
        end
        wl_q <= (rst || strobe_out.wr_n) ? 4'h0 : wl_q + 4'h1; // low time of shared strobe
    end
    sequence s_wr; $fell(strobe_out.wr_n) ##1 !strobe_out.wr_n ##1 strobe_out.wr_n; endsequence
    sequence s_rd; $fell(strobe_out.rd_n) ##1 !strobe_out.rd_n ##1 strobe_out.rd_n; endsequence
    a_port_latch: assert property (port_wr |-> ##[1:2] third_io_port_out == wd_q)
        else $error("port latch wrong");
    a_wr_strobe: assert property (port_wr && port_strobe_enable && !xmem_busy |-> ##[3:4] s_wr)
        else $error("port write strobe wrong");
    a_rd_strobe: assert property (port_rd && port_strobe_enable && !xmem_busy |-> ##[3:5] s_rd)
        else $error("port read strobe wrong");
    a_read_value: assert property (port_rd |=> port_rdata == $past(port_pins_in, 2))
        else $error("read value wrong");
    a_quiet_off: assert property ((port_wr || port_rd) && !port_strobe_enable && !xmem_busy
        |-> (strobe_out.rd_n && strobe_out.wr_n) [*8])
        else $error("strobe while disabled");
    a_wr_len: assert property ($rose(strobe_out.wr_n) |-> wl_q == len)
        else $error("write strobe length wrong");
    a_first_ptr: assert property (xmem_busy && !sq && !cq && !bus_out.addr_oe_n
        |-> !strobe_out.rd_n || !strobe_out.wr_n)
        else $error("first pointer address outside strobe");
    a_second_ptr: assert property (xmem_busy && sq && !cq && !strobe_out.cs_n
        |-> !bus_out.addr_oe_n)
        else $error("second pointer address missing");
    a_code_quiet: assert property (xmem_busy && cq |-> strobe_out.cs_n && strobe_out.rd_n)
        else $error("select during fetch");
    a_write_drive: assert property (xmem_busy && wq && !cq && !strobe_out.wr_n
        |-> !strobe_out.cs_n && !bus_out.data_oe_n && bus_out.data == xd_q)
        else $error("data write drive wrong");
endmodule : psx_port_strobe_assertions
bind psx_port_strobe psx_port_strobe_assertions u_chk (.clk, .rst, .port_strobe_enable, .port_wr,
    .port_wdata, .port_rd, .port_pins_in, .port_rdata, .third_io_port_out, .xmem_req, .xmem_write,
    .xmem_code, .xmem_ptr_sel, .xmem_wdata, .stretch, .xmem_busy, .bus_out, .strobe_out);
`default_nettype wire

// file: dv/psx_periph.sv
// external logic on the port and a small data memory
`timescale 1ns/1ps
`default_nettype none
module psx_periph (
    input wire logic clk,
    input wire logic rst,
    input wire psx_pkg::psx_strobe_type strobe_out,
    input wire psx_pkg::psx_bus_type bus_out,
    input wire logic [7:0] third_io_port_out,
    output logic [7:0] port_pins_in,
    output logic [7:0] bus_data_in,
    output logic [7:0] cap_q
);
    logic rd_q, wr_q, cs_q;
    logic [7:0] last_q;
    wire logic mrd = !strobe_out.cs_n && !strobe_out.rd_n && !bus_out.addr_oe_n;
    // next byte only after the read pulse; byte captured at write pulse end
    always_ff @(posedge clk) begin
        // select is judged as it stood during the pulse; it rises with a memory strobe
        rd_q <= rst || strobe_out.rd_n;
        wr_q <= rst || strobe_out.wr_n;
        cs_q <= rst || strobe_out.cs_n;
        if (rst) port_pins_in <= 8'h3C;
        else if (strobe_out.rd_n && !rd_q && cs_q) port_pins_in <= port_pins_in + 8'h01;
        if (strobe_out.wr_n && !wr_q && cs_q) cap_q <= third_io_port_out;
        if (rst) last_q <= 8'h00;
        else if (mrd) last_q <= bus_out.addr[7:0] ^ 8'h5A;
    end
    // unselected bus shows the inverse, never a stale match
    assign bus_data_in = mrd ? bus_out.addr[7:0] ^ 8'h5A : ~last_q;
endmodule : psx_periph
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the port strobe block
`timescale 1ns/1ps
`default_nettype none
`include "psx_defines.svh"
module tb;
    logic clk = 1'b0, rst = 1'b1, port_strobe_enable = 1'b0, port_wr = 1'b0, port_rd = 1'b0;
    logic xmem_req = 1'b0, xmem_write = 1'b0, xmem_code = 1'b0, xmem_ptr_sel = 1'b0;
    logic [7:0] port_wdata = 8'h00, xmem_wdata = 8'h00;
    logic [15:0] xmem_addr = 16'h0000;
    logic [`PSX_STRETCH_W-1:0] stretch = '0;
    wire logic [7:0] port_pins_in, port_rdata, third_io_port_out, xmem_rdata, bus_data_in, cap;
    wire logic xmem_busy;
    psx_pkg::psx_bus_type bus_out;
    psx_pkg::psx_strobe_type strobe_out;
    int n_mismatch = 0, checks = 0, cyc = 0, lows = 0;
    psx_port_strobe dut (.clk, .rst, .port_strobe_enable, .port_wr, .port_wdata, .port_rd,
        .port_pins_in, .port_rdata, .third_io_port_out, .xmem_req, .xmem_write, .xmem_code,
        .xmem_ptr_sel, .xmem_addr, .xmem_wdata, .stretch, .xmem_busy, .xmem_rdata, .bus_data_in,
        .bus_out, .strobe_out);
    psx_periph u_periph (.clk, .rst, .strobe_out, .bus_out, .third_io_port_out, .port_pins_in,
        .bus_data_in, .cap_q(cap));
    always #2.5 clk = ~clk;
    // cycle count, strobe activity, hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!strobe_out.rd_n || !strobe_out.wr_n) lows <= lows + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks = checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic t_write(input logic [7:0] d);
        int c;
        port_wdata = d;
        pulse(port_wr);
        for (int i = 0; i < 4 && third_io_port_out !== d; i++) @(negedge clk);
        chk("port_out", d, third_io_port_out);
        c = cyc;
        for (int i = 0; i < 8 && strobe_out.wr_n !== 1'b0; i++) @(negedge clk);
        chk("wr_delay", 16'h0002, 16'(cyc - c));
        repeat (6) @(negedge clk);
        chk("captured", d, cap);
    endtask : t_write
    task automatic t_read(input logic [7:0] e, input logic on);
        int c;
        pulse(port_rd);
        @(negedge clk);
        chk("rdata", e, port_rdata);
        c = cyc;
        for (int i = 0; i < 8 && strobe_out.rd_n !== 1'b0; i++) @(negedge clk);
        if (on) chk("rd_delay", 16'h0003, 16'(cyc - c));
        repeat (5) @(negedge clk);
        chk("rdata_kept", e, port_rdata);
        chk("next_byte", e + {7'h00, on}, port_pins_in);
    endtask : t_read
    task automatic t_off();
        int l;
        l = lows;
        port_strobe_enable = 1'b0;
        port_wdata = 8'hC3;
        pulse(port_wr);
        repeat (8) @(negedge clk);
        t_read(8'h3E, 1'b0);
        chk("quiet", 16'(l), 16'(lows));
        port_strobe_enable = 1'b1;
    endtask : t_off
    task automatic t_xmem(input logic w, cd, sl, input logic [2:0] st, output int n);
        {xmem_write, xmem_code, xmem_ptr_sel, stretch} = {w, cd, sl, st};
        xmem_addr = 16'h1230 + 16'(st);
        xmem_wdata = 8'hA5;
        pulse(xmem_req);
        for (int i = 0; i < 3 && xmem_busy !== 1'b1; i++) @(negedge clk);
        for (n = 0; n < 40 && xmem_busy === 1'b1; n++) @(negedge clk);
        if (!w && !cd) chk("xmem_rdata", xmem_addr[7:0] ^ 8'h5A, xmem_rdata);
        @(negedge clk);
    endtask : t_xmem
    initial begin
        int a, b;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        port_strobe_enable = 1'b1;
        t_write(8'h96);
        t_write(8'h69);
        t_read(8'h3C, 1'b1);
        t_read(8'h3D, 1'b1);
        t_off();
        t_xmem(1'b0, 1'b1, 1'b0, 3'h0, a);
        t_xmem(1'b0, 1'b1, 1'b0, 3'h7, b);
        chk("fetch_len", 16'(a), 16'(b));
        t_xmem(1'b1, 1'b0, 1'b0, 3'h0, a);
        t_xmem(1'b1, 1'b0, 1'b1, 3'h3, b);
        chk("stretch_len", 16'(a + 3), 16'(b));
        t_xmem(1'b0, 1'b0, 1'b0, 3'h2, a);
        t_xmem(1'b0, 1'b0, 1'b1, 3'h1, b);
        final_report();
    end
    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
endmodule : tb
`default_nettype wire
